// *** hdl/dup_device.sv ***
`timescale 1ns/1ps
module dup_device
	import dup_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	dup_bus_if.device bus,
	input wire logic [1:0] ser_rx_i,
	output logic [1:0] ser_tx_o,
	input wire logic [7:0] pdata_i,
	output logic [7:0] pdata_o,
	output logic pdata_oe_o,
	input wire logic ack_n_i,
	input wire logic busy_i,
	input wire logic direction_source_pin_i,
	output logic auto_line_feed_n_o,
	output logic auto_line_feed_n_oe_o
);

	dup_dev_t s;
	dup_dev_t next_s;
	logic [1:0] sel_ch;
	logic sel_p;
	logic rd_fall;
	logic wr_fall;
	logic dir_in;
	logic tick;

	////////////////////////////////////////////////////////////////////////////////

	assign sel_ch = {~bus.sel_b_n, ~bus.sel_a_n};
	assign sel_p = ~bus.sel_p_n;
	// strobes come from logic on this clock, so edges are taken without a synchroniser
	assign rd_fall = ~bus.rd_n & s.rd_q;
	assign wr_fall = ~bus.wr_n & s.wr_q;
	assign dir_in = s.dsrc[1] ? s.ctrl[DUP_CTRL_DIR] : s.iosel_in;
	assign tick = (s.pre == DUP_HALF_TICK_CYC - 6'h01);

	assign bus.d_dout = s.dout;
	assign bus.d_doe = s.doe;
	assign ser_tx_o = s.txo;
	assign pdata_o = s.pdata;
	assign pdata_oe_o = s.pdoe;
	// open drain: the pin is only ever pulled low
	assign auto_line_feed_n_o = 1'b0;
	assign auto_line_feed_n_oe_o = s.ctrl[DUP_CTRL_AFD];

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		int nb;
		int tot;
		logic pen;
		logic eps;
		logic dl;
		logic rx_in;
		logic [7:0] m;
		logic [7:0] d;
		logic [15:0] div;
		logic [16:0] bit_ht;
		logic [10:0] fr;
		nb = 8;
		tot = 10;
		pen = 1'b0;
		eps = 1'b0;
		dl = 1'b0;
		rx_in = 1'b1;
		m = 8'hFF;
		d = 8'h00;
		div = 16'h0001;
		bit_ht = 17'h00002;
		fr = 11'h7FF;
		next_s = s;
		next_s.rd_q = bus.rd_n;
		next_s.wr_q = bus.wr_n;
		next_s.doe = ~bus.rd_n & ((|sel_ch) | sel_p);
		next_s.dsrc = {s.dsrc[0], direction_source_pin_i};
		next_s.ack = {s.ack[0], ack_n_i};
		next_s.busy = {s.busy[0], busy_i};
		next_s.pin = {s.pin[0], pdata_i};
		next_s.pre = tick ? 6'h00 : s.pre + 6'h01;
		next_s.pdoe = ~dir_in;

		// parallel port: only A1..A0 take part in the decode
		if (wr_fall & sel_p) begin
			case (bus.addr[1:0])
				DUP_PP_DATA: next_s.pdata = bus.data;
				DUP_PP_CTRL: next_s.ctrl = bus.data;
				DUP_PP_IOSEL: begin
					// other patterns are ignored so a stray write cannot flip the port
					if (bus.data == DUP_IOSEL_OUT) begin
						next_s.iosel_in = 1'b0;
					end else if (bus.data == DUP_IOSEL_IN) begin
						next_s.iosel_in = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rd_fall & sel_p) begin
			case (bus.addr[1:0])
				DUP_PP_DATA: next_s.dout = s.pin[1];
				DUP_PP_STAT: next_s.dout = {~s.busy[1], s.ack[1], 6'h00};
				DUP_PP_CTRL: next_s.dout = s.ctrl;
				default: next_s.dout = {7'h00, dir_in};
			endcase
		end

		for (int c = 0; c < 2; c++) begin
			nb = 5 + int'(s.ch[c].lcr[1:0]);
			pen = s.ch[c].lcr[DUP_LCR_PEN];
			eps = s.ch[c].lcr[DUP_LCR_EPS];
			dl = s.ch[c].lcr[DUP_LCR_DLAB];
			tot = nb + int'(pen) + 2;
			m = 8'hFF >> (8 - nb);
			div = ({s.ch[c].dlm, s.ch[c].dll} == 16'h0000) ? 16'h0001 :
				{s.ch[c].dlm, s.ch[c].dll};
			bit_ht = {div, 1'b0};
			next_s.ch[c].rxs = {s.ch[c].rxs[0], ser_rx_i[c]};

			if (wr_fall & sel_ch[c]) begin
				case (bus.addr)
					DUP_UART_DATA: begin
						if (dl) begin
							next_s.ch[c].dll = bus.data;
						end else begin
							next_s.ch[c].thr = bus.data;
							next_s.ch[c].thr_full = 1'b1;
						end
					end
					DUP_UART_IER: begin
						if (dl) begin
							next_s.ch[c].dlm = bus.data;
						end else begin
							next_s.ch[c].ier = bus.data;
						end
					end
					DUP_UART_LCR: next_s.ch[c].lcr = bus.data;
					DUP_UART_MCR: next_s.ch[c].mcr = bus.data;
					DUP_UART_SCR: next_s.ch[c].scr = bus.data;
					default: ;
				endcase
			end
			// read clears come first so that an engine event in the same cycle wins
			if (rd_fall & sel_ch[c]) begin
				case (bus.addr)
					DUP_UART_DATA: begin
						next_s.dout = dl ? s.ch[c].dll : s.ch[c].rbr;
						next_s.ch[c].dr = dl & s.ch[c].dr;
					end
					DUP_UART_IER: next_s.dout = dl ? s.ch[c].dlm : s.ch[c].ier;
					DUP_UART_IIR: next_s.dout = DUP_IIR_NONE;
					DUP_UART_LCR: next_s.dout = s.ch[c].lcr;
					DUP_UART_MCR: next_s.dout = s.ch[c].mcr;
					DUP_UART_LSR: begin
						next_s.dout = {1'b0, ~s.ch[c].thr_full & ~s.ch[c].tx_busy,
							~s.ch[c].thr_full, 1'b0, s.ch[c].ferr, s.ch[c].perr,
							s.ch[c].oerr, s.ch[c].dr};
						next_s.ch[c].oerr = 1'b0;
						next_s.ch[c].perr = 1'b0;
						next_s.ch[c].ferr = 1'b0;
					end
					DUP_UART_MSR: next_s.dout = DUP_MSR_NONE;
					default: next_s.dout = s.ch[c].scr;
				endcase
			end

			// transmitter: start, data LSB first, parity, stop
			if (~s.ch[c].tx_busy & next_s.ch[c].thr_full) begin
				d = next_s.ch[c].thr & m;
				fr = 11'h7FF;
				fr[0] = 1'b0;
				for (int i = 0; i < 8; i++) begin
					if (i < nb) begin
						fr[i + 1] = d[i];
					end
				end
				if (pen) begin
					fr[nb + 1] = eps ? ^d : ~^d;
				end
				next_s.ch[c].thr_full = 1'b0;
				next_s.ch[c].tx_busy = 1'b1;
				next_s.ch[c].tx_line = fr[0];
				next_s.ch[c].tx_sh = fr >> 1;
				next_s.ch[c].tx_cnt = 4'(tot - 1);
				next_s.ch[c].tx_tmr = bit_ht - 17'h00001;
			end else if (s.ch[c].tx_busy & tick) begin
				if (s.ch[c].tx_tmr != 17'h00000) begin
					next_s.ch[c].tx_tmr = s.ch[c].tx_tmr - 17'h00001;
				end else if (s.ch[c].tx_cnt == 4'h0) begin
					next_s.ch[c].tx_busy = 1'b0;
				end else begin
					next_s.ch[c].tx_line = s.ch[c].tx_sh[0];
					next_s.ch[c].tx_sh = s.ch[c].tx_sh >> 1;
					next_s.ch[c].tx_cnt = s.ch[c].tx_cnt - 4'h1;
					next_s.ch[c].tx_tmr = bit_ht - 17'h00001;
				end
			end
			// in loop-back the line out stays marking and the receiver hears the transmitter
			next_s.txo[c] = s.ch[c].mcr[DUP_MCR_LOOP] | s.ch[c].tx_line;
			rx_in = s.ch[c].mcr[DUP_MCR_LOOP] ? s.ch[c].tx_line : s.ch[c].rxs[1];

			// receiver: first sample half a bit after the start edge, then each bit centre
			if (~s.ch[c].rx_busy) begin
				if (~rx_in) begin
					next_s.ch[c].rx_busy = 1'b1;
					next_s.ch[c].rx_idx = 4'h0;
					next_s.ch[c].rx_tmr = {1'b0, div} - 17'h00001;
				end
			end else if (tick) begin
				if (s.ch[c].rx_tmr != 17'h00000) begin
					next_s.ch[c].rx_tmr = s.ch[c].rx_tmr - 17'h00001;
				end else if ((s.ch[c].rx_idx == 4'h0) & rx_in) begin
					next_s.ch[c].rx_busy = 1'b0;
				end else begin
					next_s.ch[c].rx_sh[s.ch[c].rx_idx] = rx_in;
					next_s.ch[c].rx_idx = s.ch[c].rx_idx + 4'h1;
					next_s.ch[c].rx_tmr = bit_ht - 17'h00001;
					if (int'(s.ch[c].rx_idx) == tot - 1) begin
						d = next_s.ch[c].rx_sh[8:1] & m;
						next_s.ch[c].rx_busy = 1'b0;
						next_s.ch[c].rbr = d;
						next_s.ch[c].perr = pen &
							(next_s.ch[c].rx_sh[nb + 1] != (eps ? ^d : ~^d));
						next_s.ch[c].ferr = ~rx_in;
						next_s.ch[c].oerr = next_s.ch[c].oerr | next_s.ch[c].dr;
						next_s.ch[c].dr = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= DUP_DEV_RST;
		end else begin
			s <= next_s;
		end
	end

endmodule

// *** hdl/dup_host.sv ***
`timescale 1ns/1ps
module dup_host
	import dup_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	dup_bus_if.host bus,
	input wire logic [2:0] sw_addr_i,
	input wire logic [7:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [7:0] sw_rdata_o
);

	dup_host_t s;
	dup_host_t next_s;

	assign bus.addr = s.addr;
	assign bus.sel_a_n = s.sel_n[0];
	assign bus.sel_b_n = s.sel_n[1];
	assign bus.sel_p_n = s.sel_n[2];
	assign bus.rd_n = s.rd_n;
	assign bus.wr_n = s.wr_n;
	assign bus.h_dout = s.wdata;
	assign bus.h_doe = s.doe;
	assign sw_rdata_o = s.sw_rdata;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_s = s;
		next_s.sw_rdata = 8'h00;
		if (sw_rd_i) begin
			case (sw_addr_i)
				DUP_HREG_TARGET: next_s.sw_rdata = {3'h0, s.unit, s.addr};
				DUP_HREG_WDATA: next_s.sw_rdata = s.wdata;
				DUP_HREG_STATUS: begin
					next_s.sw_rdata = {6'h00, s.done, s.st != H_IDLE};
					next_s.done = 1'b0;
				end
				DUP_HREG_RDATA: next_s.sw_rdata = s.rdata;
				default: ;
			endcase
		end
		// target and data are frozen while a cycle runs; a go while busy is dropped
		if (sw_wr_i & (s.st == H_IDLE)) begin
			case (sw_addr_i)
				DUP_HREG_TARGET: begin
					next_s.addr = sw_wdata_i[2:0];
					next_s.unit = sw_wdata_i[4:3];
				end
				DUP_HREG_WDATA: next_s.wdata = sw_wdata_i;
				DUP_HREG_GO: begin
					next_s.is_rd = sw_wdata_i[0];
					next_s.st = H_SETUP;
					next_s.done = 1'b0;
					// one-hot select, so two units never share the bus
					next_s.sel_n = ~(3'h1 << s.unit);
					next_s.doe = ~sw_wdata_i[0];
				end
				default: ;
			endcase
		end
		case (s.st)
			H_SETUP: begin
				next_s.st = H_STROBE;
				next_s.cnt = DUP_STROBE_CYC - 2'h1;
				next_s.rd_n = ~s.is_rd;
				next_s.wr_n = s.is_rd;
			end
			H_STROBE: begin
				if (s.cnt == 2'h0) begin
					if (s.is_rd) begin
						next_s.rdata = bus.data;
					end
					next_s.rd_n = 1'b1;
					next_s.wr_n = 1'b1;
					next_s.st = H_HOLD;
				end else begin
					next_s.cnt = s.cnt - 2'h1;
				end
			end
			H_HOLD: begin
				next_s.sel_n = 3'h7;
				next_s.doe = 1'b0;
				next_s.done = 1'b1;
				next_s.st = H_IDLE;
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= DUP_HOST_RST;
		end else begin
			s <= next_s;
		end
	end

endmodule

// *** inc/dup_bus_if.sv ***
`timescale 1ns/1ps
interface dup_bus_if
	import dup_pkg::*;
();
	logic [2:0] addr;
	logic sel_a_n;
	logic sel_b_n;
	logic sel_p_n;
	logic rd_n;
	logic wr_n;
	logic [7:0] h_dout;
	logic h_doe;
	logic [7:0] d_dout;
	logic d_doe;
	logic [7:0] data;

	// resolved data bus; undriven bus floats high through the pull-ups
	assign data = h_doe ? h_dout : (d_doe ? d_dout : DUP_BUS_IDLE);

	modport host (
		output addr, sel_a_n, sel_b_n, sel_p_n, rd_n, wr_n, h_dout, h_doe,
		input data
	);
	modport device (
		input addr, sel_a_n, sel_b_n, sel_p_n, rd_n, wr_n, data,
		output d_dout, d_doe
	);
endinterface

// *** inc/dup_pkg.sv ***
package dup_pkg;

	// unit select codes used by the host controller
	localparam logic [1:0] DUP_UNIT_A = 2'h0;
	localparam logic [1:0] DUP_UNIT_B = 2'h1;
	localparam logic [1:0] DUP_UNIT_P = 2'h2;

	// serial channel register offsets
	localparam logic [2:0] DUP_UART_DATA = 3'h0;
	localparam logic [2:0] DUP_UART_IER = 3'h1;
	localparam logic [2:0] DUP_UART_IIR = 3'h2;
	localparam logic [2:0] DUP_UART_LCR = 3'h3;
	localparam logic [2:0] DUP_UART_MCR = 3'h4;
	localparam logic [2:0] DUP_UART_LSR = 3'h5;
	localparam logic [2:0] DUP_UART_MSR = 3'h6;
	localparam logic [2:0] DUP_UART_SCR = 3'h7;

	// parallel port register offsets
	localparam logic [1:0] DUP_PP_DATA = 2'h0;
	localparam logic [1:0] DUP_PP_STAT = 2'h1;
	localparam logic [1:0] DUP_PP_CTRL = 2'h2;
	localparam logic [1:0] DUP_PP_IOSEL = 2'h3;

	// field positions
	localparam int DUP_LCR_PEN = 3;
	localparam int DUP_LCR_EPS = 4;
	localparam int DUP_LCR_DLAB = 7;
	localparam int DUP_MCR_LOOP = 4;
	localparam int DUP_CTRL_DIR = 5;
	localparam int DUP_CTRL_AFD = 1;

	localparam logic [7:0] DUP_IOSEL_OUT = 8'hAA;
	localparam logic [7:0] DUP_IOSEL_IN = 8'h55;
	localparam logic [7:0] DUP_IIR_NONE = 8'h01;
	localparam logic [7:0] DUP_MSR_NONE = 8'h00;
	localparam logic [7:0] DUP_BUS_IDLE = 8'hFF;

	// bit time is divisor * 2 half-ticks of 40 clocks: 47 bps .. 3.1 Mbps at 250 MHz
	localparam logic [5:0] DUP_HALF_TICK_CYC = 6'h28;
	localparam logic [1:0] DUP_STROBE_CYC = 2'h3;

	// host controller register offsets
	localparam logic [2:0] DUP_HREG_TARGET = 3'h0;
	localparam logic [2:0] DUP_HREG_WDATA = 3'h1;
	localparam logic [2:0] DUP_HREG_GO = 3'h2;
	localparam logic [2:0] DUP_HREG_STATUS = 3'h3;
	localparam logic [2:0] DUP_HREG_RDATA = 3'h4;

	typedef struct packed {
		logic [7:0] dll, dlm, ier, lcr, mcr, scr, rbr, thr;
		logic dr, oerr, perr, ferr, thr_full;
		logic tx_busy, tx_line;
		logic [10:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [16:0] tx_tmr;
		logic [1:0] rxs;
		logic rx_busy;
		logic [10:0] rx_sh;
		logic [3:0] rx_idx;
		logic [16:0] rx_tmr;
	} dup_chan_t;

	localparam dup_chan_t DUP_CHAN_RST = '{dll: 8'h01, tx_line: 1'b1, rxs: 2'h3, default: '0};

	typedef struct packed {
		dup_chan_t [1:0] ch;
		logic [5:0] pre;
		logic [7:0] pdata, ctrl;
		logic iosel_in, pdoe;
		logic [1:0] dsrc, ack, busy, txo;
		logic [1:0][7:0] pin;
		logic rd_q, wr_q, doe;
		logic [7:0] dout;
	} dup_dev_t;

	localparam dup_dev_t DUP_DEV_RST = '{ch: '{DUP_CHAN_RST, DUP_CHAN_RST}, pdoe: 1'b1,
		ack: 2'h3, txo: 2'h3, rd_q: 1'b1, wr_q: 1'b1, default: '0};

	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} dup_hstate_t;

	typedef struct packed {
		dup_hstate_t st;
		logic [1:0] cnt, unit;
		logic [2:0] addr, sel_n;
		logic [7:0] wdata, rdata, sw_rdata;
		logic is_rd, done, rd_n, wr_n, doe;
	} dup_host_t;

	localparam dup_host_t DUP_HOST_RST = '{st: H_IDLE, sel_n: 3'h7, rd_n: 1'b1, wr_n: 1'b1,
		default: '0};

endpackage

// *** testbench/dup_bus_sva.sv ***
`timescale 1ns/1ps
module dup_bus_sva
	import dup_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sel_a_n,
	input wire logic sel_b_n,
	input wire logic sel_p_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic h_doe,
	input wire logic d_doe
);
	////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic any_sel;
	assign any_sel = !(sel_a_n && sel_b_n && sel_p_n);
	// a strobe is three cycles low, then released
	sequence s_low3(sig);
		!sig [*3] ##1 sig;
	endsequence
	a_one_select: assert property ($countones({!sel_a_n, !sel_b_n, !sel_p_n}) <= 1)
		else $error("two unit selects low together");
	a_write_len: assert property ($fell(wr_n) |-> s_low3(wr_n))
		else $error("write strobe width wrong");
	a_read_len: assert property ($fell(rd_n) |-> s_low3(rd_n))
		else $error("read strobe width wrong");
	// select must settle a cycle before the strobe, the device decodes in the first low cycle
	a_sel_setup: assert property (($fell(rd_n) || $fell(wr_n)) |-> $past(any_sel))
		else $error("strobe without prior select");
	a_sel_hold: assert property (($rose(rd_n) || $rose(wr_n)) |-> any_sel)
		else $error("select dropped before strobe");
	a_read_drive: assert property ($fell(rd_n) |=> d_doe [*3])
		else $error("device not driving read data");
	a_read_release: assert property ($rose(rd_n) |-> ##2 !d_doe)
		else $error("device holds bus after read");
	a_no_fight: assert property (!(h_doe && d_doe))
		else $error("both ends drive data bus");
	a_write_drive: assert property (!wr_n |-> h_doe && !d_doe)
		else $error("write data not driven by host");
endmodule

// *** testbench/dup_tb.sv ***
`timescale 1ns/1ps
module dup_tb;
	import dup_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] sw_addr_i = 3'h0;
	logic [7:0] sw_wdata_i = 8'h00;
	logic sw_wr_i = 1'b0;
	logic sw_rd_i = 1'b0;
	logic [7:0] sw_rdata_o, pdata_o, q;
	logic [7:0] pdata_i = 8'h00;
	logic [1:0] ser_tx_o, ser_rx_i;
	logic pdata_oe_o, afd_n, afd_oe;
	logic ack_n_i = 1'b1;
	logic busy_i = 1'b0;
	logic dir_pin = 1'b0;
	logic [10:0] frame;
	int err_count = 0;
	int n_compared = 0;
	////////////////////////////////////////
	dup_bus_if bus();
	// channel B is looped outside, channel A uses its internal path
	assign ser_rx_i = {ser_tx_o[1], 1'b1};
	always #2 clk_i = ~clk_i;
	dup_host i_dup_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .sw_addr_i(sw_addr_i),
		.sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o));
	dup_device i_dup_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .ser_rx_i(ser_rx_i),
		.ser_tx_o(ser_tx_o), .pdata_i(pdata_i), .pdata_o(pdata_o), .pdata_oe_o(pdata_oe_o),
		.ack_n_i(ack_n_i), .busy_i(busy_i), .direction_source_pin_i(dir_pin),
		.auto_line_feed_n_o(afd_n), .auto_line_feed_n_oe_o(afd_oe));
	dup_bus_sva i_dup_bus_sva (.clk_i(clk_i), .rst_i(rst_i), .sel_a_n(bus.sel_a_n),
		.sel_b_n(bus.sel_b_n), .sel_p_n(bus.sel_p_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
		.h_doe(bus.h_doe), .d_doe(bus.d_doe));
	////////////////////////////////////////
	task automatic wrap_up();
		if (err_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic sw(input logic wr, input logic rd, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sw_wr_i <= wr;
		sw_rd_i <= rd;
		sw_addr_i <= a;
		sw_wdata_i <= d;
		@(posedge clk_i);
		sw_wr_i <= 1'b0;
		sw_rd_i <= 1'b0;
		#1 q = sw_rdata_o;
	endtask
	// one pin-bus transfer through the host controller; result lands in q
	task automatic dev(input logic [1:0] u, input logic [2:0] a, input logic rd, input logic [7:0] d);
		int i;
		sw(1'b1, 1'b0, DUP_HREG_TARGET, {3'h0, u, a});
		sw(1'b1, 1'b0, DUP_HREG_WDATA, d);
		sw(1'b1, 1'b0, DUP_HREG_GO, {7'h00, rd});
		q = 8'h00;
		for (i = 0; i < 20 && q[1] !== 1'b1; i++)
			sw(1'b0, 1'b1, DUP_HREG_STATUS, 8'h00);
		if (q[1] !== 1'b1) begin
			err_count++;
			wrap_up();
		end
		if (rd)
			sw(1'b0, 1'b1, DUP_HREG_RDATA, 8'h00);
	endtask
	task automatic rdx(input logic [1:0] u, input logic [2:0] a, input logic [7:0] exp);
		dev(u, a, 1'b1, 8'h00);
		check({3'h0, q}, {3'h0, exp});
	endtask
	////////////////////////////////////////
	initial begin
		int i;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check(bus.data, DUP_BUS_IDLE);
		check(ser_tx_o, 11'h003);
		check(pdata_oe_o, 11'h001);
		rdx(DUP_UNIT_A, DUP_UART_LCR, 8'h00);
		dev(DUP_UNIT_A, DUP_UART_SCR, 1'b0, 8'h5A);
		dev(DUP_UNIT_B, DUP_UART_SCR, 1'b0, 8'hA5);
		rdx(DUP_UNIT_A, DUP_UART_SCR, 8'h5A);
		rdx(DUP_UNIT_B, DUP_UART_SCR, 8'hA5);
		// port ignores the top address bit, so offset 4 is its data latch
		dev(DUP_UNIT_P, 3'h4, 1'b0, 8'hC3);
		check(pdata_o, 11'h0C3);
		dev(DUP_UNIT_P, {1'b0, DUP_PP_IOSEL}, 1'b0, DUP_IOSEL_IN);
		check(pdata_oe_o, 11'h000);
		dev(DUP_UNIT_P, {1'b0, DUP_PP_IOSEL}, 1'b0, 8'h12);
		rdx(DUP_UNIT_P, {1'b0, DUP_PP_IOSEL}, 8'h01);
		@(posedge clk_i) pdata_i <= 8'h3C;
		rdx(DUP_UNIT_P, {1'b0, DUP_PP_DATA}, 8'h3C);
		dev(DUP_UNIT_P, {1'b0, DUP_PP_IOSEL}, 1'b0, DUP_IOSEL_OUT);
		check(pdata_oe_o, 11'h001);
		@(posedge clk_i) dir_pin <= 1'b1;
		dev(DUP_UNIT_P, {1'b0, DUP_PP_CTRL}, 1'b0, 8'h22);
		check(pdata_oe_o, 11'h000);
		check({afd_oe, afd_n}, 11'h002);
		dev(DUP_UNIT_P, {1'b0, DUP_PP_CTRL}, 1'b0, 8'h00);
		check(pdata_oe_o, 11'h001);
		@(posedge clk_i) busy_i <= 1'b1;
		rdx(DUP_UNIT_P, {1'b0, DUP_PP_STAT}, 8'h40);
		@(posedge clk_i) busy_i <= 1'b0;
		ack_n_i <= 1'b0;
		rdx(DUP_UNIT_P, {1'b0, DUP_PP_STAT}, 8'h80);
		// internal loop-back: 8 bits, divisor 1, ten bits of 80 clocks
		dev(DUP_UNIT_A, DUP_UART_MCR, 1'b0, 8'h10);
		dev(DUP_UNIT_A, DUP_UART_LCR, 1'b0, 8'h03);
		dev(DUP_UNIT_A, DUP_UART_DATA, 1'b0, 8'hA7);
		repeat (1000) @(posedge clk_i);
		check(ser_tx_o, 11'h003);
		rdx(DUP_UNIT_A, DUP_UART_LSR, 8'h61);
		rdx(DUP_UNIT_A, DUP_UART_DATA, 8'hA7);
		// odd parity, 5-bit characters on the same internal path
		dev(DUP_UNIT_A, DUP_UART_LCR, 1'b0, 8'h08);
		dev(DUP_UNIT_A, DUP_UART_DATA, 1'b0, 8'h13);
		repeat (1000) @(posedge clk_i);
		rdx(DUP_UNIT_A, DUP_UART_LSR, 8'h61);
		rdx(DUP_UNIT_A, DUP_UART_DATA, 8'h13);
		// channel B: divisor 2 gives 160 clocks a bit, even parity
		dev(DUP_UNIT_B, DUP_UART_LCR, 1'b0, 8'h80);
		dev(DUP_UNIT_B, DUP_UART_DATA, 1'b0, 8'h02);
		dev(DUP_UNIT_B, DUP_UART_LCR, 1'b0, 8'h1B);
		dev(DUP_UNIT_B, DUP_UART_DATA, 1'b0, 8'hB5);
		for (i = 0; i < 2000 && ser_tx_o[1] !== 1'b0; i++)
			@(posedge clk_i) #1;
		if (ser_tx_o[1] !== 1'b0) begin
			err_count++;
			wrap_up();
		end
		// start may be seen late by the polling, so sample early of mid-bit
		repeat (60) @(posedge clk_i);
		for (i = 0; i < 11; i++) begin
			#1 frame[i] = ser_tx_o[1];
			repeat (160) @(posedge clk_i);
		end
		check(frame, {1'b1, ^8'hB5, 8'hB5, 1'b0});
		rdx(DUP_UNIT_B, DUP_UART_DATA, 8'hB5);
		wrap_up();
	end
endmodule
